/* irct_carrier.v */
`timescale 1ns/1ps
`default_nettype none
`include "irct_regs.vh"

// --------------------------------------------------------------
// base clock divider and carrier generator
// --------------------------------------------------------------
module irct_carrier #(
   parameter DIV_W = 3,
   parameter PRE_W = 7
) (
   // clock and reset
   input  wire             ref_clk_in,
   input  wire             rst_in,
   // control
   input  wire             run_in,
   input  wire [DIV_W-1:0] div_sel_in,
   input  wire [7:0]       high_in,
   input  wire [7:0]       low_in,
   // outputs
   output wire             base_tick_out,
   output wire             carrier_out,
   output wire             period_tick_out
);

   reg  [PRE_W-1:0] pre_q;
   reg  [7:0]       ph_cnt_q;
   reg              high_q;
   wire [PRE_W-1:0] pre_mask;

   // mask of the low div_sel bits of the prescaler
   assign pre_mask = ~({PRE_W{1'b1}} << div_sel_in);
   assign base_tick_out = run_in && ((pre_q & pre_mask) == pre_mask);
   assign carrier_out = high_q;
   // period ends at the last base clock of the low phase
   assign period_tick_out = base_tick_out && !high_q &&
                            (ph_cnt_q == 8'h00);

   // prescaler, restarted while stopped
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pre_q <= {PRE_W{1'b0}};
      end else if (!run_in) begin
         pre_q <= {PRE_W{1'b0}};
      end else begin
         pre_q <= pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         high_q   <= 1'b1;
         ph_cnt_q <= 8'h00;
      end else if (!run_in) begin
         high_q   <= 1'b1;
         ph_cnt_q <= high_in;
      end else if (base_tick_out) begin
         if (ph_cnt_q == 8'h00) begin
            high_q   <= !high_q;
            ph_cnt_q <= high_q ? low_in : high_in;
         end else begin
            ph_cnt_q <= ph_cnt_q - 8'h01;
         end
      end
   end

endmodule // irct_carrier

`default_nettype wire

/* irct_ir_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// emitter driver and receiver module
// ----
module irct_ir_partner (
   // clock
   input  wire logic ref_clk_in,
   // emitter side
   input  wire logic tx_level_in,
   input  wire logic tx_oe_in,
   input  wire logic clr_in,
   output var int    pulse_cnt_out,
   // receiver side
   input  wire logic rx_cmd_in,
   output var logic  rx_pin_out
);
   logic last_q;
   logic drv_q;
   logic line;
   initial begin
      last_q = 1'b0;
      drv_q = 1'b0;
      pulse_cnt_out = 0;
      rx_pin_out = 1'b0;
   end
   // released line holds the inverse of the last driven level
   assign line = tx_oe_in ? tx_level_in : ~drv_q;
   // count driven rising edges, echo receive level
   always @(posedge ref_clk_in) begin
      last_q <= line;
      if (tx_oe_in) drv_q <= tx_level_in;
      rx_pin_out <= rx_cmd_in;
      if (clr_in) pulse_cnt_out <= 0;
      else if (tx_oe_in && line && !last_q)
         pulse_cnt_out <= pulse_cnt_out + 1;
   end
endmodule // irct_ir_partner
`default_nettype wire

/* irct_regs.vh */
`ifndef IRCT_REGS_VH
`define IRCT_REGS_VH

// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define IRCT_OFS_CTRL      5'h00
`define IRCT_OFS_CARRIER   5'h04
`define IRCT_OFS_INTERVAL  5'h08
`define IRCT_OFS_COUNTER   5'h0C
`define IRCT_OFS_STATUS    5'h10

// --------------------------------------------------------------
// control register fields
// --------------------------------------------------------------
`define IRCT_CTL_EN        0
`define IRCT_CTL_DIR       1
`define IRCT_CTL_FINE      2
`define IRCT_CTL_POL       3
`define IRCT_CTL_DATA      4
`define IRCT_CTL_IRQEN     5
`define IRCT_CTL_RELOAD    6
`define IRCT_CTL_BURST     7
`define IRCT_CTL_ENV_LO    8
`define IRCT_CTL_ENV_HI    9
`define IRCT_CTL_EDGE_LO   10
`define IRCT_CTL_EDGE_HI   11
`define IRCT_CTL_DIV_LO    12
`define IRCT_CTL_DIV_HI    14
`define IRCT_CTL_MLEVEL    16
`define IRCT_CTL_MOE       17
`define IRCT_CTL_W         18

// --------------------------------------------------------------
// status register fields
// --------------------------------------------------------------
`define IRCT_ST_IFLAG      0
`define IRCT_ST_OVFL       1
`define IRCT_ST_STARTED    2

// --------------------------------------------------------------
// encodings and reset values
// --------------------------------------------------------------
`define IRCT_ENV_MOD       2'h1
`define IRCT_ENV_CONT      2'h2
`define IRCT_EDGE_FALL     2'h0
`define IRCT_EDGE_RISE     2'h1
`define IRCT_CTL_RST       18'h00000
`define IRCT_CAR_RST       16'h0000
`define IRCT_CNT_ZERO      16'h0000
`define IRCT_CNT_ONE       16'h0001
`define IRCT_CNT_MAX       16'hFFFF
`define IRCT_BURST_LOAD    16'h0001
`define IRCT_GAP_LIMIT     2'h2

`endif

/* irct_timer.v */
// Function
// - base clock is system clock over 2^divide
// - carrier high count+1, low count+1
// - latch carrier, polarity, data per interval
// - enable drives idle level from polarity
// - fine select picks base or carrier count
// - data one sends carrier, zero idles
// - transmit starts on enable and direction
// - zero count reloads, resamples, flags, interrupts
// - clearing enable or direction ends transmit
// - interval lasts interval value plus one
// - envelope pin shows data xor polarity
// - envelope mode picks modulated or continuous
// - edge select qualifies receive edges
// - receive starts counting at first edge
// - later edges capture level and count
// - standard receive flags every capture
// - counter wrap on a cycle with no edge sets overflow flag
// - receive runs until direction or disable
// - burst mode counts edges, no capture
// - two silent carrier periods set flag in burst
// - entering burst mode loads one
// - reload bit still clears in burst
// - disabled pin follows manual bits
// - interrupt only when interrupt enable bit set
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irct_regs.vh"

module irct_timer (
   // clock and reset
   input  wire        ref_clk_in,
   input  wire        rst_in,
   // avalon-mm slave
   input  wire [4:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output wire        avs_waitrequest_out,
   // infrared pins
   input  wire        ir_in_pin_in,
   output reg         ir_out_pin_out,
   output reg         ir_out_pin_oe_out,
   output reg         envelope_pin_out,
   output reg         envelope_pin_oe_out,
   // interrupt request
   output wire        irq_out
);

   // -----------------------------------------------------------
   // declarations
   // -----------------------------------------------------------
   reg  [`IRCT_CTL_W-1:0] ctrl_q;
   reg  [15:0] carrier_q;
   reg  [15:0] mt_q;
   reg  [15:0] cnt_q;
   reg         iflag_q;
   reg         ovfl_q;
   reg         ack_q;
   reg         rx_sync1_q;
   reg         rx_sync2_q;
   reg         rx_prev_q;
   reg         tx_act_q;
   reg         rx_started_q;
   reg         burst_q;
   reg  [15:0] car_lat_q;
   reg         pol_lat_q;
   reg         data_lat_q;
   reg  [1:0]  gap_q;
   wire        base_tick;
   wire        carrier;
   wire        period_tick;
   wire        count_tick;
   wire        tx_act;
   wire        rx_act;
   wire        tx_start;
   wire        edge_q;
   wire        rise;
   wire        fall;
   wire        acc;
   wire [31:0] wmask;
   wire [31:0] ctrl_wr;
   wire        wr_ctrl;
   wire        wr_car;
   wire        wr_mt;
   wire        wr_st;
   wire [15:0] car_sel;
   wire        car_out;
   wire        mod_out;

   // -----------------------------------------------------------
   // helper functions
   // -----------------------------------------------------------
   // byte enables to a bit mask
   function [31:0] be_mask;
      input [3:0] be;
      integer i;
      begin
         be_mask = 32'h00000000;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               be_mask[i*8 +: 8] = 8'hFF;
            end
         end
      end
   endfunction

   // address match for a register offset
   function is_reg;
      input [4:0] addr;
      input [4:0] ofs;
      begin
         is_reg = (addr[4:2] == ofs[4:2]);
      end
   endfunction

   function edge_ok;
      input [1:0] sel;
      input       r;
      input       f;
      begin
         case (sel)
            `IRCT_EDGE_FALL: edge_ok = f;
            `IRCT_EDGE_RISE: edge_ok = r;
            default:         edge_ok = r | f;
         endcase
      end
   endfunction

   // -----------------------------------------------------------
   // bus slave
   // -----------------------------------------------------------
   // one wait cycle per access, answer on the second
   assign acc = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = acc & ~ack_q;
   assign wmask = be_mask(avs_byteenable_in);
   assign wr_ctrl = avs_write_in & ack_q &
                    is_reg(avs_address_in, `IRCT_OFS_CTRL);
   assign wr_car = avs_write_in & ack_q &
                   is_reg(avs_address_in, `IRCT_OFS_CARRIER);
   assign wr_mt = avs_write_in & ack_q &
                  is_reg(avs_address_in, `IRCT_OFS_INTERVAL);
   assign wr_st = avs_write_in & ack_q &
                  is_reg(avs_address_in, `IRCT_OFS_STATUS);
   assign ctrl_wr = ({14'h0000, ctrl_q} & ~wmask) |
                    (avs_writedata_in & wmask);

   // ack toggles so every request sees one wait cycle
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc & ~ack_q;
      end
   end

   // read data, unmapped reads return zero
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         avs_readdata_out <= 32'h00000000;
      end else if (avs_read_in & ~ack_q) begin
         case (avs_address_in[4:2])
            `IRCT_OFS_CTRL >> 2:
               avs_readdata_out <= {14'h0000, ctrl_q};
            `IRCT_OFS_CARRIER >> 2:
               avs_readdata_out <= {16'h0000, carrier_q};
            `IRCT_OFS_INTERVAL >> 2:
               avs_readdata_out <= {16'h0000, mt_q};
            `IRCT_OFS_COUNTER >> 2:
               avs_readdata_out <= {16'h0000, cnt_q};
            `IRCT_OFS_STATUS >> 2:
               avs_readdata_out <= {29'h00000000, rx_started_q,
                                    ovfl_q, iflag_q};
            default:
               avs_readdata_out <= 32'h00000000;
         endcase
      end
   end

   // -----------------------------------------------------------
   // receive pin synchroniser and edges
   // -----------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_sync1_q <= 1'b0;
         rx_sync2_q <= 1'b0;
         rx_prev_q  <= 1'b0;
      end else begin
         rx_sync1_q <= ir_in_pin_in;
         rx_sync2_q <= rx_sync1_q;
         rx_prev_q  <= rx_sync2_q;
      end
   end

   assign rise = rx_sync2_q & ~rx_prev_q;
   assign fall = ~rx_sync2_q & rx_prev_q;
   assign edge_q = rx_act &
      edge_ok(ctrl_q[`IRCT_CTL_EDGE_HI:`IRCT_CTL_EDGE_LO], rise, fall);

   // -----------------------------------------------------------
   // modes and carrier
   // -----------------------------------------------------------
   // transmit while enable and direction set
   assign tx_act = ctrl_q[`IRCT_CTL_EN] & ctrl_q[`IRCT_CTL_DIR];
   // receive while enabled and direction clear
   assign rx_act = ctrl_q[`IRCT_CTL_EN] & ~ctrl_q[`IRCT_CTL_DIR];
   assign tx_start = tx_act & ~tx_act_q;
   // transmit uses the latched carrier timing
   assign car_sel = tx_act_q ? car_lat_q : carrier_q;
   assign count_tick = ctrl_q[`IRCT_CTL_FINE] ? base_tick
                                              : period_tick;

   irct_carrier #(
      .DIV_W (3),
      .PRE_W (7)
   ) u_carrier (
      .ref_clk_in      (ref_clk_in),
      .rst_in          (rst_in),
      .run_in          (ctrl_q[`IRCT_CTL_EN] & ~tx_start),
      .div_sel_in      (ctrl_q[`IRCT_CTL_DIV_HI:`IRCT_CTL_DIV_LO]),
      .high_in         (car_sel[15:8]),
      .low_in          (car_sel[7:0]),
      .base_tick_out   (base_tick),
      .carrier_out     (carrier),
      .period_tick_out (period_tick)
   );

   // -----------------------------------------------------------
   // control and carrier registers
   // -----------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q    <= `IRCT_CTL_RST;
         carrier_q <= `IRCT_CAR_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= ctrl_wr[`IRCT_CTL_W-1:0];
         end
         if (wr_car) begin
            carrier_q <= (carrier_q & ~wmask[15:0]) |
                         (avs_writedata_in[15:0] & wmask[15:0]);
         end
         // captured pin level wins over software
         if (edge_q & rx_started_q & ~ctrl_q[`IRCT_CTL_BURST]) begin
            ctrl_q[`IRCT_CTL_DATA] <= rx_sync2_q;
         end
      end
   end

   // -----------------------------------------------------------
   // interval counter and interval register
   // -----------------------------------------------------------
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q        <= `IRCT_CNT_ZERO;
         mt_q         <= `IRCT_CNT_ZERO;
         tx_act_q     <= 1'b0;
         rx_started_q <= 1'b0;
         burst_q      <= 1'b0;
         car_lat_q    <= `IRCT_CAR_RST;
         pol_lat_q    <= 1'b0;
         data_lat_q   <= 1'b0;
         gap_q        <= 2'h0;
      end else begin
         tx_act_q <= tx_act;
         burst_q  <= ctrl_q[`IRCT_CTL_BURST];
         if (wr_mt) begin
            mt_q <= (mt_q & ~wmask[15:0]) |
                    (avs_writedata_in[15:0] & wmask[15:0]);
         end
         if (!rx_act) begin
            rx_started_q <= 1'b0;
            gap_q        <= 2'h0;
         end
         if (tx_start) begin
            cnt_q      <= mt_q;
            car_lat_q  <= carrier_q;
            pol_lat_q  <= ctrl_q[`IRCT_CTL_POL];
            data_lat_q <= ctrl_q[`IRCT_CTL_DATA];
         end else if (tx_act & count_tick) begin
            if (cnt_q == `IRCT_CNT_ZERO) begin
               cnt_q      <= mt_q;
               car_lat_q  <= carrier_q;
               pol_lat_q  <= ctrl_q[`IRCT_CTL_POL];
               data_lat_q <= ctrl_q[`IRCT_CTL_DATA];
            end else begin
               cnt_q <= cnt_q - `IRCT_CNT_ONE;
            end
         end
         if (rx_act) begin
            if (edge_q & ~rx_started_q) begin
               rx_started_q <= 1'b1;
               cnt_q        <= `IRCT_CNT_ZERO;
            end else if (edge_q) begin
               gap_q <= 2'h0;
               if (ctrl_q[`IRCT_CTL_BURST]) begin
                  mt_q <= mt_q + `IRCT_CNT_ONE;
               end else begin
                  mt_q <= cnt_q;
               end
               if (ctrl_q[`IRCT_CTL_RELOAD]) begin
                  cnt_q <= `IRCT_CNT_ZERO;
               end else if (count_tick) begin
                  cnt_q <= cnt_q + `IRCT_CNT_ONE;
               end
            end else if (rx_started_q) begin
               if (count_tick) begin
                  cnt_q <= cnt_q + `IRCT_CNT_ONE;
               end
               if (period_tick && gap_q != `IRCT_GAP_LIMIT) begin
                  gap_q <= gap_q + 2'h1;
               end
            end
         end
         if (ctrl_q[`IRCT_CTL_BURST] & ~burst_q) begin
            mt_q <= `IRCT_BURST_LOAD;
         end
      end
   end

   // -----------------------------------------------------------
   // status flags
   // -----------------------------------------------------------
   // sticky, write one to clear, set wins
   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         iflag_q <= 1'b0;
         ovfl_q  <= 1'b0;
      end else begin
         if (wr_st & avs_writedata_in[`IRCT_ST_IFLAG] &
             avs_byteenable_in[0]) begin
            iflag_q <= 1'b0;
         end
         if (wr_st & avs_writedata_in[`IRCT_ST_OVFL] &
             avs_byteenable_in[0]) begin
            ovfl_q <= 1'b0;
         end
         if (tx_act & ~tx_start & count_tick &
             (cnt_q == `IRCT_CNT_ZERO)) begin
            iflag_q <= 1'b1;
         end
         if (edge_q & rx_started_q & ~ctrl_q[`IRCT_CTL_BURST]) begin
            iflag_q <= 1'b1;
         end
         // two silent periods mark carrier loss
         if (rx_act & rx_started_q & ~edge_q &
             ctrl_q[`IRCT_CTL_BURST] & period_tick &
             (gap_q == `IRCT_GAP_LIMIT - 2'h1)) begin
            iflag_q <= 1'b1;
         end
         if (rx_act & rx_started_q & ~edge_q & count_tick &
             (cnt_q == `IRCT_CNT_MAX)) begin
            ovfl_q <= 1'b1;
         end
      end
   end

   assign irq_out = ctrl_q[`IRCT_CTL_IRQEN] & (iflag_q | ovfl_q);

   // -----------------------------------------------------------
   // output pins
   // -----------------------------------------------------------
   // carrier inverted by polarity
   assign car_out = carrier ^ pol_lat_q;
   assign mod_out = data_lat_q ? car_out : pol_lat_q;

   always @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ir_out_pin_out      <= 1'b0;
         ir_out_pin_oe_out   <= 1'b0;
         envelope_pin_out    <= 1'b0;
         envelope_pin_oe_out <= 1'b0;
      end else if (!ctrl_q[`IRCT_CTL_EN]) begin
         ir_out_pin_out      <= ctrl_q[`IRCT_CTL_MLEVEL];
         ir_out_pin_oe_out   <= ctrl_q[`IRCT_CTL_MOE];
         envelope_pin_out    <= 1'b0;
         envelope_pin_oe_out <= 1'b0;
      end else if (!tx_act_q) begin
         ir_out_pin_out      <= ctrl_q[`IRCT_CTL_POL];
         ir_out_pin_oe_out   <= 1'b1;
         envelope_pin_out    <= ctrl_q[`IRCT_CTL_POL];
         envelope_pin_oe_out <= 1'b0;
      end else begin
         ir_out_pin_oe_out <= 1'b1;
         case (ctrl_q[`IRCT_CTL_ENV_HI:`IRCT_CTL_ENV_LO])
            `IRCT_ENV_MOD: begin
               ir_out_pin_out      <= mod_out;
               envelope_pin_out    <= data_lat_q ^ pol_lat_q;
               envelope_pin_oe_out <= 1'b1;
            end
            `IRCT_ENV_CONT: begin
               ir_out_pin_out      <= car_out;
               envelope_pin_out    <= data_lat_q ^ pol_lat_q;
               envelope_pin_oe_out <= 1'b1;
            end
            default: begin
               ir_out_pin_out      <= mod_out;
               envelope_pin_out    <= pol_lat_q;
               envelope_pin_oe_out <= 1'b0;
            end
         endcase
      end
   end

endmodule // irct_timer

`default_nettype wire

/* irct_timer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker for the ir timer
// ----
module irct_timer_checker (
   // clock and reset
   input wire logic        ref_clk_in,
   input wire logic        rst_in,
   // register bus
   input wire logic [4:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0]  avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   // pins
   input wire logic        ir_in_pin_in,
   input wire logic        ir_out_pin_out,
   input wire logic        ir_out_pin_oe_out,
   input wire logic        envelope_pin_out,
   input wire logic        envelope_pin_oe_out,
   input wire logic        irq_out
);
   logic       req;
   logic       wr_done;
   logic [2:0] since_wr_q;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // request and completed write
   assign req = avs_read_in | avs_write_in;
   assign wr_done = avs_write_in & ~avs_waitrequest_out;
   // cycles since last completed write, saturating
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) since_wr_q <= 3'h7;
      else if (wr_done) since_wr_q <= 3'h0;
      else if (since_wr_q != 3'h7) since_wr_q <= since_wr_q + 3'h1;
   end
   sequence s_req_start;
      req && !$past(req);
   endsequence
   sequence s_two_cycle;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   a_first_wait: assert property (s_req_start |-> s_two_cycle)
      else $error("access not two cycles");
   a_wait_bound: assert property (req |-> ##[0:1] !avs_waitrequest_out)
      else $error("waitrequest held too long");
   a_idle_nowait: assert property (!req |-> !avs_waitrequest_out)
      else $error("waitrequest without request");
   a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
      && avs_address_in[4:2] > 3'h4 |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_rd_stable: assert property (!avs_read_in |=> $stable(avs_readdata_out))
      else $error("read data moved without read");
   a_reset_quiet: assert property ($fell(rst_in) |-> !irq_out &&
      !ir_out_pin_oe_out && !envelope_pin_oe_out)
      else $error("outputs active after reset");
   a_oe_by_write: assert property (
      $changed(ir_out_pin_oe_out) |-> since_wr_q <= 3'h4)
      else $error("pin enable moved without write");
   a_env_by_write: assert property (
      $changed(envelope_pin_oe_out) |-> since_wr_q <= 3'h5)
      else $error("envelope enable moved without write");
endmodule // irct_timer_checker
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ----
   // signals and model
   // ----
   logic        ref_clk_in = 1'b0, rst_in = 1'b1;
   logic [4:0]  avs_address_in = 5'h00;
   logic        avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
   logic        avs_waitrequest_out, ir_in_pin_in, irq_out;
   logic        ir_out_pin_out, ir_out_pin_oe_out;
   logic        envelope_pin_out, envelope_pin_oe_out;
   logic        rx_cmd = 1'b0, clr = 1'b0;
   int          pulses, n_mismatch = 0, n_checks = 0, seed = 16;
   logic [31:0] q, r, mdl [8];
   logic [31:0] msk [8] = '{32'h37F7E, 32'hFFFF, 32'hFFFF,
                            32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [31:0] tc [4] = '{32'h37, 32'h0F, 32'h12F, 32'h23F};
   logic [31:0] tp [4] = '{32'h1, 32'h0, 32'h0, 32'h1};
   logic [31:0] te [4] = '{32'h0, 32'h0, 32'h3, 32'h2};
   always #2 ref_clk_in = ~ref_clk_in;
   irct_timer u_irct_timer (
      .ref_clk_in          (ref_clk_in),
      .rst_in              (rst_in),
      .avs_address_in      (avs_address_in),
      .avs_read_in         (avs_read_in),
      .avs_write_in        (avs_write_in),
      .avs_writedata_in    (avs_writedata_in),
      .avs_byteenable_in   (4'hF),
      .avs_readdata_out    (avs_readdata_out),
      .avs_waitrequest_out (avs_waitrequest_out),
      .ir_in_pin_in        (ir_in_pin_in),
      .ir_out_pin_out      (ir_out_pin_out),
      .ir_out_pin_oe_out   (ir_out_pin_oe_out),
      .envelope_pin_out    (envelope_pin_out),
      .envelope_pin_oe_out (envelope_pin_oe_out),
      .irq_out             (irq_out));
   irct_ir_partner u_irct_ir_partner (
      .ref_clk_in    (ref_clk_in),
      .tx_level_in   (ir_out_pin_out),
      .tx_oe_in      (ir_out_pin_oe_out),
      .clr_in        (clr),
      .pulse_cnt_out (pulses),
      .rx_cmd_in     (rx_cmd),
      .rx_pin_out    (ir_in_pin_in));
   // ----
   // compare, close, bus access
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // settle, then count emitted pulses over 40 cycles
   task automatic count40();
      wait_n(10);
      clr <= 1'b1;
      wait_n(1);
      clr <= 1'b0;
      wait_n(40);
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      wait_n(10);
      rst_in <= 1'b0;
      for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
      // random writes everywhere, readback against model
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         mdl[i] = r & msk[i];
         bus(1'b1, 5'(i * 4), (i == 0) ? mdl[0] : r);
      end
      for (int i = 0; i < 8; i++) rd(5'(i * 4), mdl[i]);
      chk({ir_out_pin_oe_out, ir_out_pin_oe_out & ir_out_pin_out},
          {mdl[0][17], mdl[0][17] & mdl[0][16]});
      $display("test registers done");
      // transmit settings table
      bus(1'b1, 5'h04, 32'h0);
      bus(1'b1, 5'h08, 32'h3);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 5'h00, tc[i]);
         count40();
         chk(32'(pulses > 18 && pulses < 22), tp[i]);
         if (tp[i] == 0) chk(ir_out_pin_out, 1'b1);
         chk({envelope_pin_oe_out, envelope_pin_oe_out
             & envelope_pin_out}, te[i]);
         chk(irq_out, tc[i][5]);
      end
      bus(1'b1, 5'h00, 32'h0);
      wait_n(8);
      chk(ir_out_pin_oe_out, 1'b0);
      bus(1'b0, 5'h10, 32'h0);
      chk(q[1:0], 2'h1);
      bus(1'b1, 5'h10, 32'h3);
      rd(5'h10, 32'h0);
      $display("test transmit done");
      // receive: rising edges, reload on capture
      bus(1'b1, 5'h00, 32'h465);
      rx_cmd <= 1'b1;
      wait_n(30);
      rx_cmd <= 1'b0;
      wait_n(10);
      rd(5'h08, 32'h3);
      wait_n(20);
      rx_cmd <= 1'b1;
      wait_n(10);
      bus(1'b0, 5'h08, 32'h0);
      chk(32'(q > 59 && q < 64), 32'h1);
      bus(1'b0, 5'h00, 32'h0);
      chk(q[4], 1'b1);
      bus(1'b0, 5'h10, 32'h0);
      chk(q[0], 1'b1);
      chk(irq_out, 1'b1);
      // burst count: load, count an edge, carrier loss
      bus(1'b1, 5'h00, 32'h4E5);
      rd(5'h08, 32'h1);
      bus(1'b1, 5'h10, 32'h3);
      rx_cmd <= 1'b0;
      wait_n(6);
      rx_cmd <= 1'b1;
      wait_n(20);
      rd(5'h08, 32'h2);
      bus(1'b0, 5'h10, 32'h0);
      chk(q[0], 1'b1);
      // no edge for a full count: counter wraps
      wait_n(65536);
      bus(1'b0, 5'h10, 32'h0);
      chk(q[1], 1'b1);
      $display("test receive done");
      stop_test();
   end
endmodule // testbench
bind irct_timer irct_timer_checker u_irct_timer_checker (.*);
`default_nettype wire
